// *** jib_pkg.sv ***
/*
 * jib_pkg: constants, chain layout and carrier structs of the
 * identification and boundary-scan data registers of the test port.
 * Assumes an outside tap controller that supplies the selected
 * instruction and the capture/shift/update state levels on tck.
 */
package jib_pkg;

    // =========================================================
    // register sizes and instruction codes
    localparam int       BSR_LEN    = 122;
    localparam int       ID_LEN     = 32;
    localparam logic [2:0] IR_EXTEST = 3'h0;
    localparam logic [2:0] IR_PART_IDENTIFICATION = 3'h1;
    localparam logic [2:0] IR_SAMPLE = 3'h4;

    // =========================================================
    // identification fields (values arbitrary, not a real part)
    localparam int       ID_REV_LSB = 28;
    localparam int       ID_DC_LSB  = 22;
    localparam int       ID_DEV_LSB = 12;
    localparam int       ID_MFG_LSB = 1;
    localparam logic [3:0]  ID_REVISION = 4'h0;
    localparam logic [5:0]  ID_DESIGN_CTR = 6'h2a;
    localparam logic [9:0]  ID_DEVICE = 10'h155;
    localparam logic [10:0] ID_MFG = 11'h2aa;
    localparam logic        ID_MARK = 1'h1;

    // =========================================================
    // chain layout
    localparam int UPPER_BASE  = 0;
    localparam int UPPER_N     = 3;
    localparam int ADDR_BASE   = 9;
    localparam int ADDR_N      = 24;
    localparam int ADDR_EN_POS = 57;
    localparam int PORT_BASE   = 58;
    localparam int PORT_N      = 8;
    localparam int SCL_POS     = 82;
    localparam int SDA_POS     = 84;
    localparam int TOUT1_POS   = 86;
    localparam int TOUT0_POS   = 87;
    localparam int CLK_POS     = 88;
    localparam int TIN1_POS    = 89;
    localparam int TIN0_POS    = 90;
    localparam int UART0_POS   = 91;
    localparam int UART1_POS   = 95;
    localparam int HIZ_POS     = 99;
    localparam int DATA_BASE   = 100;
    localparam int DATA_N      = 11;

    // =========================================================
    // reset values
    localparam logic [BSR_LEN-1:0] BSR_RST = 122'h0;
    localparam logic [ID_LEN-1:0]  ID_RST  = 32'h0;

    typedef enum logic [1:0] {
        JIB_SEL_NONE = 2'b00,
        JIB_SEL_ID   = 2'b01,
        JIB_SEL_BSR  = 2'b10
    } jib_sel_type;

    typedef struct packed {
        logic       tck;
        logic       tdi;
        logic       capture_dr;
        logic       shift_dr;
        logic       update_dr;
        logic [2:0] instr;
    } jib_tap_type;

    typedef struct packed {
        logic [2:0]  upper;   // [0] is the highest address pin
        logic [23:0] addr;
        logic [7:0]  port;
        logic        scl;
        logic        sda;
        logic        clk;
        logic [1:0]  tin;
        logic [1:0]  rxd;
        logic [1:0]  cts;
        logic        hiz;
        logic [10:0] data;
    } jib_pin_in_type;

    typedef struct packed {
        logic [2:0]  upper;
        logic [2:0]  upper_oe;
        logic [23:0] addr;
        logic        addr_oe;
        logic [7:0]  port;
        logic [7:0]  port_oe;
        logic        scl;
        logic        scl_oe;
        logic        sda;
        logic        sda_oe;
        logic [1:0]  tout;
        logic [1:0]  txd;
        logic [1:0]  rts;
        logic [10:0] data;
        logic        data_oe;
    } jib_pin_out_type;

endpackage : jib_pkg

// *** jib_tester.sv ***
/*
 * jib_tester: board tester model driving tck, tap levels and tdi.
 * Assumes a free system clock; tck stands low between frames.
 */
`timescale 1ns/1ps
module jib_tester (
    input  wire logic            sys_clk_in,
    input  wire logic            tdo_in,
    output jib_pkg::jib_tap_type tap_out
);
    // ==========================================================
    // frame driver
    initial begin
        tap_out = '0;
        tap_out.instr = jib_pkg::IR_PART_IDENTIFICATION;
    end
    task automatic q2();
        repeat (2) @(negedge sys_clk_in);
    endtask : q2
    // levels move mid phase, so they never race a tck edge
    task automatic scan(input logic [2:0] ins, input int n,
                        input logic [121:0] din, input logic upd,
                        output logic [121:0] dout);
        dout = '0;
        tap_out.instr = ins;
        repeat (8) @(negedge sys_clk_in);
        tap_out.capture_dr = 1'b1;
        q2();
        tap_out.tck = 1'b1;
        q2();
        tap_out.capture_dr = 1'b0;
        tap_out.shift_dr = 1'b1;
        q2();
        for (int i = 0; i < n; i++) begin
            tap_out.tck = 1'b0;
            q2();
            tap_out.tdi = din[i];
            q2();
            dout[i] = tdo_in;
            tap_out.tck = 1'b1;
            q2();
            if (i == n - 1) begin
                tap_out.shift_dr = 1'b0;
                tap_out.update_dr = upd;
                tap_out.tdi = ~din[i];
            end
            q2();
        end
        tap_out.tck = 1'b0;
        q2();
        tap_out.update_dr = 1'b0;
        q2();
    endtask : scan
endmodule : jib_tester

// *** jib_top.sv ***
/*
 * jib_top: identification register and boundary-scan register data
 * paths, run from the system clock, which oversamples tck.
 * Assumes tck is at least four system clocks per half period and that
 * the tap state levels and instruction change mid phase, away from both tck edges.
 */
`timescale 1ns/1ps
module jib_top (
    input  wire logic                    sys_clk_in,
    input  wire logic                    rst_b_in,
    input  wire jib_pkg::jib_tap_type    tap_in,
    input  wire jib_pkg::jib_pin_in_type pins_in,
    output logic                         tdo_out,
    output logic                         tdo_oe_out,
    output logic [1:0]                   dr_sel_out,
    output logic                         bsr_drive_out,
    output jib_pkg::jib_pin_out_type     pins_out
);

    // =========================================================
    // functions
    function automatic jib_pkg::jib_sel_type dec_sel(
        input logic [2:0] instr
    );
        jib_pkg::jib_sel_type s;
        s = jib_pkg::JIB_SEL_NONE;
        if (instr == jib_pkg::IR_PART_IDENTIFICATION) begin
            s = jib_pkg::JIB_SEL_ID;
        end else if (instr == jib_pkg::IR_EXTEST ||
                     instr == jib_pkg::IR_SAMPLE) begin
            s = jib_pkg::JIB_SEL_BSR;
        end
        return s;
    endfunction : dec_sel

    function automatic logic [jib_pkg::ID_LEN-1:0] id_value();
        logic [jib_pkg::ID_LEN-1:0] v;
        v = jib_pkg::ID_RST;
        v[jib_pkg::ID_REV_LSB +: 4]  = jib_pkg::ID_REVISION;
        v[jib_pkg::ID_DC_LSB +: 6]   = jib_pkg::ID_DESIGN_CTR;
        v[jib_pkg::ID_DEV_LSB +: 10] = jib_pkg::ID_DEVICE;
        v[jib_pkg::ID_MFG_LSB +: 11] = jib_pkg::ID_MFG;
        v[0]                         = jib_pkg::ID_MARK;
        return v;
    endfunction : id_value

    // output and control cells capture their own update stage, since
    // no functional pin logic is visible from here
    function automatic logic [jib_pkg::BSR_LEN-1:0] capture_vec(
        input jib_pkg::jib_pin_in_type   p,
        input logic [jib_pkg::BSR_LEN-1:0] upd
    );
        logic [jib_pkg::BSR_LEN-1:0] v;
        v = upd;
        for (int k = 0; k < jib_pkg::UPPER_N; k++) begin
            v[jib_pkg::UPPER_BASE + 3*k] = p.upper[k];
        end
        for (int j = 0; j < jib_pkg::ADDR_N; j++) begin
            v[jib_pkg::ADDR_BASE + 2*j] = p.addr[23-j];
        end
        for (int k = 0; k < jib_pkg::PORT_N; k++) begin
            v[jib_pkg::PORT_BASE + 3*k] = p.port[k];
        end
        for (int d = 0; d < jib_pkg::DATA_N; d++) begin
            v[jib_pkg::DATA_BASE + 2*d] = p.data[d];
        end
        v[jib_pkg::SCL_POS]       = p.scl;
        v[jib_pkg::SDA_POS]       = p.sda;
        v[jib_pkg::CLK_POS]       = p.clk;
        v[jib_pkg::TIN1_POS]      = p.tin[1];
        v[jib_pkg::TIN0_POS]      = p.tin[0];
        v[jib_pkg::UART0_POS + 1] = p.rxd[0];
        v[jib_pkg::UART0_POS + 3] = p.cts[0];
        v[jib_pkg::UART1_POS + 1] = p.rxd[1];
        v[jib_pkg::UART1_POS + 3] = p.cts[1];
        v[jib_pkg::HIZ_POS]       = p.hiz;
        return v;
    endfunction : capture_vec

    // control cell at one means drive; enables only act under extest
    function automatic jib_pkg::jib_pin_out_type drive_map(
        input logic [jib_pkg::BSR_LEN-1:0] u,
        input logic                        drv
    );
        jib_pkg::jib_pin_out_type o;
        o = '0;
        for (int k = 0; k < jib_pkg::UPPER_N; k++) begin
            o.upper[k]    = u[jib_pkg::UPPER_BASE + 3*k + 1];
            o.upper_oe[k] = drv & u[jib_pkg::UPPER_BASE + 3*k + 2];
        end
        for (int j = 0; j < jib_pkg::ADDR_N; j++) begin
            o.addr[23-j] = u[jib_pkg::ADDR_BASE + 2*j + 1];
        end
        o.addr_oe = drv & u[jib_pkg::ADDR_EN_POS];
        for (int k = 0; k < jib_pkg::PORT_N; k++) begin
            o.port[k]    = u[jib_pkg::PORT_BASE + 3*k + 1];
            o.port_oe[k] = drv & u[jib_pkg::PORT_BASE + 3*k + 2];
        end
        for (int d = 0; d < jib_pkg::DATA_N; d++) begin
            o.data[d] = u[jib_pkg::DATA_BASE + 2*d + 1];
        end
        // no data enable cell below position 122: driven whenever forcing
        o.data_oe = drv;
        // serial pins have no enable cell: open drain, drive low only
        o.scl     = u[jib_pkg::SCL_POS + 1];
        o.scl_oe  = drv & ~u[jib_pkg::SCL_POS + 1];
        o.sda     = u[jib_pkg::SDA_POS + 1];
        o.sda_oe  = drv & ~u[jib_pkg::SDA_POS + 1];
        o.tout[1] = u[jib_pkg::TOUT1_POS];
        o.tout[0] = u[jib_pkg::TOUT0_POS];
        o.txd[0]  = u[jib_pkg::UART0_POS];
        o.rts[0]  = u[jib_pkg::UART0_POS + 2];
        o.txd[1]  = u[jib_pkg::UART1_POS];
        o.rts[1]  = u[jib_pkg::UART1_POS + 2];
        return o;
    endfunction : drive_map

    // =========================================================
    // synchronisers
    jib_pkg::jib_tap_type    tap_s1_r;
    jib_pkg::jib_tap_type    tap_s2_r;
    jib_pkg::jib_pin_in_type pins_s1_r;
    jib_pkg::jib_pin_in_type pins_s2_r;
    logic                    tck_d_r;
    jib_pkg::jib_tap_type    tap_s1_nxt;
    jib_pkg::jib_tap_type    tap_s2_nxt;
    jib_pkg::jib_pin_in_type pins_s1_nxt;
    jib_pkg::jib_pin_in_type pins_s2_nxt;
    logic                    tck_d_nxt;

    always_comb begin
        tap_s1_nxt  = tap_in;
        tap_s2_nxt  = tap_s1_r;
        pins_s1_nxt = pins_in;
        pins_s2_nxt = pins_s1_r;
        tck_d_nxt   = tap_s2_r.tck;
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            // reset instruction is the id code, never extest, so no
            // pin is forced in the first cycles after release
            tap_s1_r  <= '{instr: jib_pkg::IR_PART_IDENTIFICATION, default: '0};
            tap_s2_r  <= '{instr: jib_pkg::IR_PART_IDENTIFICATION, default: '0};
            pins_s1_r <= '0;
            pins_s2_r <= '0;
            tck_d_r   <= 1'b0;
        end else begin
            tap_s1_r  <= tap_s1_nxt;
            tap_s2_r  <= tap_s2_nxt;
            pins_s1_r <= pins_s1_nxt;
            pins_s2_r <= pins_s2_nxt;
            tck_d_r   <= tck_d_nxt;
        end
    end

    // =========================================================
    // data registers
    logic                          tck_rise;
    logic                          tck_fall;
    jib_pkg::jib_sel_type          sel;
    logic [jib_pkg::ID_LEN-1:0]    id_sr_r;
    logic [jib_pkg::BSR_LEN-1:0]   bsr_sr_r;
    logic [jib_pkg::BSR_LEN-1:0]   bsr_upd_r;
    logic                          tdo_r;
    logic                          tdo_oe_r;
    jib_pkg::jib_sel_type          sel_r;
    logic                          drive_r;
    jib_pkg::jib_pin_out_type      pins_r;
    logic [jib_pkg::ID_LEN-1:0]    id_sr_nxt;
    logic [jib_pkg::BSR_LEN-1:0]   bsr_sr_nxt;
    logic [jib_pkg::BSR_LEN-1:0]   bsr_upd_nxt;
    logic                          tdo_nxt;
    logic                          tdo_oe_nxt;
    logic                          drive_nxt;
    jib_pkg::jib_pin_out_type      pins_nxt;

    assign tck_rise = tap_s2_r.tck & ~tck_d_r;
    assign tck_fall = ~tap_s2_r.tck & tck_d_r;
    assign sel      = dec_sel(tap_s2_r.instr);

    always_comb begin
        id_sr_nxt   = id_sr_r;
        bsr_sr_nxt  = bsr_sr_r;
        bsr_upd_nxt = bsr_upd_r;
        tdo_nxt     = tdo_r;
        tdo_oe_nxt  = tdo_oe_r;
        if (tck_rise && tap_s2_r.capture_dr) begin
            case (sel)
                jib_pkg::JIB_SEL_ID: begin
                    id_sr_nxt = id_value();
                end
                jib_pkg::JIB_SEL_BSR: begin
                    bsr_sr_nxt = capture_vec(pins_s2_r, bsr_upd_r);
                end
                default: begin
                end
            endcase
        end else if (tck_rise && tap_s2_r.shift_dr) begin
            case (sel)
                jib_pkg::JIB_SEL_ID: begin
                    id_sr_nxt = {tap_s2_r.tdi,
                                 id_sr_r[jib_pkg::ID_LEN-1:1]};
                end
                jib_pkg::JIB_SEL_BSR: begin
                    bsr_sr_nxt = {tap_s2_r.tdi,
                                  bsr_sr_r[jib_pkg::BSR_LEN-1:1]};
                end
                default: begin
                end
            endcase
        end
        // tdo changes on falling tck so the tester samples it stable
        if (tck_fall) begin
            case (sel)
                jib_pkg::JIB_SEL_ID:  tdo_nxt = id_sr_r[0];
                jib_pkg::JIB_SEL_BSR: tdo_nxt = bsr_sr_r[0];
                default:              tdo_nxt = 1'b0;
            endcase
            tdo_oe_nxt = tap_s2_r.shift_dr &&
                         (sel != jib_pkg::JIB_SEL_NONE);
            if (tap_s2_r.update_dr && sel == jib_pkg::JIB_SEL_BSR) begin
                bsr_upd_nxt = bsr_sr_r;
            end
        end
        // refused instruction: tdo quiet at once, not at the next fall
        if (sel == jib_pkg::JIB_SEL_NONE) begin
            tdo_nxt    = 1'b0;
            tdo_oe_nxt = 1'b0;
        end
        drive_nxt = (tap_s2_r.instr == jib_pkg::IR_EXTEST);
        pins_nxt  = drive_map(bsr_upd_r, drive_r);
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            id_sr_r   <= jib_pkg::ID_RST;
            bsr_sr_r  <= jib_pkg::BSR_RST;
            bsr_upd_r <= jib_pkg::BSR_RST;
            tdo_r     <= 1'b0;
            tdo_oe_r  <= 1'b0;
            sel_r     <= jib_pkg::JIB_SEL_NONE;
            drive_r   <= 1'b0;
            pins_r    <= '0;
        end else begin
            id_sr_r   <= id_sr_nxt;
            bsr_sr_r  <= bsr_sr_nxt;
            bsr_upd_r <= bsr_upd_nxt;
            tdo_r     <= tdo_nxt;
            tdo_oe_r  <= tdo_oe_nxt;
            sel_r     <= sel;
            drive_r   <= drive_nxt;
            pins_r    <= pins_nxt;
        end
    end

    // =========================================================
    // outputs
    assign tdo_out       = tdo_r;
    assign tdo_oe_out    = tdo_oe_r;
    assign dr_sel_out    = sel_r;
    assign bsr_drive_out = drive_r;
    assign pins_out      = pins_r;

endmodule : jib_top

// *** jib_top_asserts.sv ***
/*
 * jib_top_asserts: port checker for jib_top, bound at the foot.
 * Assumes tap levels stay stable across each tck edge.
 */
`timescale 1ns/1ps
module jib_top_asserts (
    input  wire logic                     sys_clk_in,
    input  wire logic                     rst_b_in,
    input  wire jib_pkg::jib_tap_type     tap_in,
    input  wire jib_pkg::jib_pin_in_type  pins_in,
    input  wire logic                     tdo_out,
    input  wire logic                     tdo_oe_out,
    input  wire logic [1:0]               dr_sel_out,
    input  wire logic                     bsr_drive_out,
    input  wire jib_pkg::jib_pin_out_type pins_out
);
    // ==========================================================
    // selection
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_b_in);
    logic [1:0] sel_exp;
    assign sel_exp = (tap_in.instr == jib_pkg::IR_PART_IDENTIFICATION) ? 2'h1 :
                     (tap_in.instr == jib_pkg::IR_EXTEST ||
                      tap_in.instr == jib_pkg::IR_SAMPLE) ? 2'h2 : 2'h0;
    a_sel_follows: assert property (
        $stable(tap_in.instr) [*6] |-> dr_sel_out == sel_exp)
        else $error("data register select wrong");
    a_ext_drive: assert property (
        $stable(tap_in.instr) [*6] |->
        bsr_drive_out == (tap_in.instr == jib_pkg::IR_EXTEST))
        else $error("pin drive does not match instruction");
    a_oe_has_sel: assert property (
        tdo_oe_out |-> dr_sel_out != 2'h0)
        else $error("tdo enabled with no register selected");
    a_unsel_quiet: assert property (
        (dr_sel_out == 2'h0) [*4] |-> !tdo_oe_out && !tdo_out)
        else $error("tdo active while unselected");
    // ==========================================================
    // serial timing
    a_tdo_steady: assert property (
        $rose(tap_in.tck) |=> $stable(tdo_out) [*4])
        else $error("tdo moved after a rising tck");
    a_oe_shift: assert property (
        (!tap_in.shift_dr) [*8] |-> !tdo_oe_out)
        else $error("tdo enabled outside shifting");
    // ==========================================================
    // pin forcing
    a_oe_ext_only: assert property (
        (!bsr_drive_out) [*4] |-> pins_out.addr_oe == 1'b0 &&
        pins_out.upper_oe == 3'h0 && pins_out.port_oe == 8'h0 &&
        !pins_out.data_oe && !pins_out.scl_oe && !pins_out.sda_oe)
        else $error("pin enabled outside extest");
    a_open_drain: assert property (
        !(pins_out.scl_oe && pins_out.scl) &&
        !(pins_out.sda_oe && pins_out.sda))
        else $error("serial pin driven high");
    a_pins_hold: assert property (
        (!tap_in.update_dr && $stable(tap_in.instr)) [*8] |=>
        $stable(pins_out))
        else $error("forced pins changed without update");
endmodule : jib_top_asserts

bind jib_top jib_top_asserts u_jib_top_asserts (
    .sys_clk_in, .rst_b_in, .tap_in, .pins_in, .tdo_out,
    .tdo_oe_out, .dr_sel_out, .bsr_drive_out, .pins_out);

// *** testbench.sv ***
/*
 * testbench: runs jib_top through the tester model and judges both
 * chains. Assumes only the 10 MHz clock and a low reset.
 */
`timescale 1ns/1ps
module testbench;
    logic                     sys_clk_in;
    logic                     rst_b_in;
    jib_pkg::jib_tap_type     tap;
    jib_pkg::jib_pin_in_type  pins_in;
    logic                     tdo_out;
    logic                     tdo_oe_out;
    logic [1:0]               dr_sel_out;
    logic                     bsr_drive_out;
    jib_pkg::jib_pin_out_type pins_out;
    int                       err_count;
    int                       n_compared;
    localparam logic [121:0]  PRE = 122'h2_3c5a_96e1_d2f0_87b4_c369_a51e_0f2d_96;
    localparam logic [55:0]   PAT = 56'ha5c396f03c69e1;

    jib_top u_jib_top (.sys_clk_in, .rst_b_in, .tap_in(tap), .pins_in,
        .tdo_out, .tdo_oe_out, .dr_sel_out, .bsr_drive_out, .pins_out);
    jib_tester u_jib_tester (.sys_clk_in, .tdo_in(tdo_out), .tap_out(tap));

    // ==========================================================
    // expectations
    function automatic logic [121:0] cells_in(input logic [55:0] raw);
        jib_pkg::jib_pin_in_type p;
        logic [121:0]            v;
        p = raw;
        v = '0;
        for (int k = 0; k < 3; k++) v[3*k] = p.upper[k];
        for (int k = 0; k < 24; k++) v[55-2*k] = p.addr[k];
        for (int k = 0; k < 8; k++) v[58+3*k] = p.port[k];
        for (int k = 0; k < 11; k++) v[100+2*k] = p.data[k];
        {v[82], v[84], v[88], v[89], v[90]} = {p.scl, p.sda, p.clk, p.tin};
        {v[92], v[94], v[96], v[98]} = {p.rxd[0], p.cts[0], p.rxd[1], p.cts[1]};
        v[99] = p.hiz;
        return v;
    endfunction : cells_in
    function automatic jib_pkg::jib_pin_out_type pins_exp(input logic [121:0] b);
        jib_pkg::jib_pin_out_type o;
        o = '0;
        for (int k = 0; k < 3; k++) o.upper[k] = b[3*k+1];
        for (int k = 0; k < 3; k++) o.upper_oe[k] = b[3*k+2];
        for (int k = 0; k < 24; k++) o.addr[k] = b[56-2*k];
        for (int k = 0; k < 8; k++) o.port[k] = b[59+3*k];
        for (int k = 0; k < 8; k++) o.port_oe[k] = b[60+3*k];
        for (int k = 0; k < 11; k++) o.data[k] = b[101+2*k];
        o.addr_oe = b[57];
        {o.scl, o.scl_oe, o.sda, o.sda_oe} = {b[83], ~b[83], b[85], ~b[85]};
        o.tout = {b[86], b[87]};
        o.txd = {b[95], b[91]};
        o.rts = {b[97], b[93]};
        o.data_oe = 1'b1;
        return o;
    endfunction : pins_exp
    task automatic check(input logic [127:0] got, input logic [127:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : check

    // ==========================================================
    // scenarios
    task automatic t_id();
        logic [121:0] got;
        u_jib_tester.scan(jib_pkg::IR_PART_IDENTIFICATION, 32, '0, 1'b0, got);
        check(got[0], 1'b1);
        check(got[31:28], jib_pkg::ID_REVISION);
        check(got[27:22], jib_pkg::ID_DESIGN_CTR);
        check(got[21:12], jib_pkg::ID_DEVICE);
        check(got[11:1], jib_pkg::ID_MFG);
        check(dr_sel_out, 2'h1);
        check(tdo_oe_out, 1'b0);
    endtask : t_id
    task automatic t_refuse();
        logic [121:0] got;
        u_jib_tester.scan(3'h7, 8, '1, 1'b1, got);
        check(got, 122'h0);
        check(dr_sel_out, 2'h0);
    endtask : t_refuse
    task automatic t_sample();
        logic [121:0] got;
        @(negedge sys_clk_in);
        pins_in = PAT;
        u_jib_tester.scan(jib_pkg::IR_SAMPLE, 122, PRE, 1'b1, got);
        check(got, cells_in(PAT));
        check(bsr_drive_out, 1'b0);
    endtask : t_sample
    task automatic t_extest();
        logic [121:0] got;
        @(negedge sys_clk_in);
        pins_in = ~PAT;
        u_jib_tester.scan(jib_pkg::IR_EXTEST, 122, PRE, 1'b1, got);
        check(got, cells_in(~PAT) | (PRE & ~cells_in('1)));
        repeat (8) @(negedge sys_clk_in);
        check(pins_out, pins_exp(PRE));
        check(bsr_drive_out, 1'b1);
    endtask : t_extest

    // ==========================================================
    // run control
    task automatic report_and_stop();
        if (err_count == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop
    initial begin
        sys_clk_in = 1'b0;
        forever #50 sys_clk_in = ~sys_clk_in;
    end
    initial begin
        err_count = 0;
        n_compared = 0;
        rst_b_in = 1'b0;
        pins_in = PAT;
        repeat (3) @(negedge sys_clk_in);
        rst_b_in = 1'b1;
        t_id();
        t_refuse();
        t_sample();
        t_extest();
        report_and_stop();
    end
    initial begin
        repeat (20000) @(posedge sys_clk_in);
        err_count++;
        report_and_stop();
    end
endmodule : testbench
